/* dv/sar_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sar_analog_model (
	input  wire logic       hclk,
	input  wire logic [2:0] channel_select,
	input  wire logic       conv_power_on,
	input  wire logic [7:0] sar_dac_code,
	input  wire logic [7:0] level [8],
	input  wire logic       slow,
	output logic            sar_compare
);
	logic now;
	logic late;

	// Without the reference powered there is no valid trial level to compare.
	assign now = conv_power_on && (level[channel_select] >= sar_dac_code);

	// A slow comparator settles one clock later than a prompt one.
	always_ff @(posedge hclk) begin
		late <= now;
	end

	assign sar_compare = slow ? late : now;
endmodule

`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import sar_adc_pkg::*;

	typedef struct {
		string       nm;
		logic [31:0] v;
	} note_t;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        comparator_result = 1'b0;
	logic        ring_osc_clk = 1'b0;
	logic        sleep_instruction = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  lv [8] = '{default: 8'h00};
	logic        hreadyout, hresp, sar_compare, sar_busy, conv_power_on;
	logic        reference_source, comparator_enable, comparator_output_enable;
	logic        comparator_out_pin, comparator_out_pin_oe, amp_one_enable;
	logic        amp_two_enable, wake_up, irq_request;
	logic [31:0] hrdata;
	logic [7:0]  sar_dac_code;
	logic [2:0]  channel_select, pin_config_field, amp_one_gain, amp_two_gain;
	note_t       q[$];
	logic        dph = 1'b0;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;

	sar_adc_control uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .sar_compare, .comparator_result,
		.ring_osc_clk, .sleep_instruction, .sar_dac_code,
		.sar_busy, .channel_select, .conv_power_on,
		.reference_source, .comparator_enable,
		.comparator_output_enable, .comparator_out_pin,
		.comparator_out_pin_oe, .pin_config_field,
		.amp_one_enable, .amp_two_enable, .amp_one_gain,
		.amp_two_gain, .wake_up, .irq_request
	);

	sar_analog_model far (
		.hclk, .channel_select, .conv_power_on, .sar_dac_code,
		.level(lv), .slow, .sar_compare
	);

	initial forever #12.5 hclk = ~hclk;

	// The ring oscillator is free running and unrelated in phase to the bus clock.
	initial forever #165.3 ring_osc_clk = ~ring_osc_clk;

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read data is judged when the data phase closes, against the oldest note.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
		if (dph && hreadyout === 1'b1) begin
			note_t t;
			t = q.pop_front();
			chk(t.nm, t.v, hrdata);
			chk("hresp", 32'h0, hresp);
		end
		if (hreadyout === 1'b1)
			dph <= hsel & htrans[1] & ~hwrite;
	end

	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		q.push_back('{nm, {24'h0, e}});
		bus(idx, 1'b0, 8'h00);
	endtask

	task automatic wt(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge hclk);
			n++;
		end
	endtask

	task automatic conv(input logic [1:0] ck, input logic [2:0] ch, input logic m);
		int n;
		int s;
		int d;
		d = 4 << (2 * ck);
		lv[ch] <= 8'($urandom);
		slow <= (ck != 2'h0) & 1'($urandom);
		wr(IDX_IRQ_MASK, {7'h0, m});
		wr(IDX_PIN_CLOCK, {6'h0, ck});
		wr(IDX_RUN_CHANNEL, {5'h01, ch});
		repeat (40) @(posedge hclk);
		wr(IDX_RUN_CHANNEL, {5'h03, ch});
		@(negedge hclk);
		s = cyc;
		chk("busy", 32'h1, sar_busy);
		chk("dac", 32'h80, sar_dac_code);
		chk("chan", ch, channel_select);
		chk("power", 32'h1, conv_power_on);
		@(posedge hclk);
		if (ck == CLK_SEL_RING) begin
			sleep_instruction <= 1'b1;
			wt(wake_up, 1'b1, 400, n);
			chk("wake", 32'h1, n < 400);
			chk("sleepdone", 32'h0, sar_busy);
			@(posedge hclk);
			sleep_instruction <= 1'b0;
		end else begin
			wr(IDX_RUN_CHANNEL, {5'h01, ~ch});
			@(negedge hclk);
			chk("runheld", 32'h1, sar_busy);
			chk("chheld", ch, channel_select);
			wt(sar_busy, 1'b0, 3000, n);
			n = cyc - s;
			chk("periods", 32'h1, n >= 8 * d - 1 && n <= 8 * d + 8);
			@(posedge hclk);
		end
		rd(IDX_RESULT, lv[ch], "result");
		rd(IDX_IRQ_STATUS, 8'h01, "done");
		rd(IDX_RUN_CHANNEL, {5'h01, ch}, "runclr");
		wr(IDX_RUN_CHANNEL, {5'h01, ~ch});
		@(negedge hclk);
		chk("chgate", ch, channel_select);
		chk("irq", m, irq_request);
		@(posedge hclk);
		wr(IDX_IRQ_STATUS, 8'h00);
		rd(IDX_IRQ_STATUS, 8'h00, "clear");
		repeat (2 * d) @(posedge hclk);
	endtask

	initial begin
		int n;
		logic [7:0] r;
		void'($urandom(32'hB66FEFC1));
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk("rstout", 32'h1, {sar_busy, channel_select, conv_power_on, reference_source,
			comparator_enable, comparator_output_enable, pin_config_field, amp_one_enable,
			amp_two_enable, amp_one_gain, amp_two_gain, irq_request, hreadyout});
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(IDX_RUN_CHANNEL, 8'h00, "rst9");
		rd(IDX_PIN_CLOCK, 8'h00, "rstb");
		rd(IDX_GAIN, 8'h00, "rstc");
		wr(8'h3F, 8'hA5);
		rd(8'h3F, 8'h00, "unmapped");
		for (int i = 0; i < 6; i++) begin
			// The last two passes switch the comparator off to see its pin gated.
			r = {1'($urandom), ~i[2], i[0], 5'($urandom)};
			comparator_result <= i[1] | i[2];
			wr(IDX_PIN_CLOCK, r);
			// The pin flop follows the stored field and the synchronised result one edge later.
			repeat (2) @(negedge hclk);
			chk("cfg", r[7:2], {reference_source, comparator_enable,
				comparator_output_enable, pin_config_field});
			chk("cmp", {r[6] & (i[1] | i[2]), r[6] & r[5]},
				{comparator_out_pin, comparator_out_pin_oe});
			@(posedge hclk);
			rd(IDX_PIN_CLOCK, r, "cfgrd");
			r = {i[0], ~i[0], 3'(5 - i), 3'(i)};
			wr(IDX_GAIN, r);
			@(negedge hclk);
			chk("gain", r, {amp_two_enable, amp_one_enable, amp_two_gain,
				amp_one_gain});
			@(posedge hclk);
			rd(IDX_GAIN, r, "gainrd");
		end
		// The comparator pin stays quiet while conversions run.
		comparator_result <= 1'b0;
		for (int i = 0; i < 12; i++)
			conv((i < 8) ? 2'h0 : 2'(i - 8), (i < 8) ? 3'(i) : 3'($urandom), i[0]);
		wr(IDX_IRQ_MASK, 8'h00);
		wr(IDX_RUN_CHANNEL, 8'h1B);
		sleep_instruction <= 1'b1;
		@(negedge hclk);
		chk("sbusy", 32'h1, sar_busy);
		wt(sar_busy, 1'b0, 40, n);
		chk("abort", 32'h1, n < 40);
		chk("pdown", 32'h0, conv_power_on);
		@(posedge hclk);
		sleep_instruction <= 1'b0;
		wt(conv_power_on, 1'b1, 8, n);
		chk("pback", 32'h1, n < 8);
		@(posedge hclk);
		wr(IDX_RUN_CHANNEL, 8'h00);
		// The power bit lands on the data-phase edge and the reference flop one edge later.
		repeat (2) @(negedge hclk);
		chk("poff", 32'h0, conv_power_on);
		end_sim();
	end
endmodule

`default_nettype wire

/* rtl/sar_adc_control.sv */
// Function
// - Writing run bit starts a conversion
// - Completion or sleep shutoff clears run bit
// - Power bit low turns reference off
// - Channel field picks input zero to seven
// - Channel changes only when flag, run low
// - Reference bit picks supply or reference pin
// - Comparator enable bit switches comparator
// - Output bit drives comparator to pin
// - Pin field sets analog, digital, reference
// - Clock field picks divide 4/16/64, ring
// - Gain codes give gains one to 32
// - Amplifier enable bits insert gain stages
// - Completion loads result, clears run, flags
// - Sleep converts only on ring clock
// - Sleep completion stores, clears, may wake
// - Sleep without interrupt enable stops conversion
// - Control registers reset to zero
// - Flag sets always; request needs mask
// - Successive approximation yields eight-bit value
`timescale 1ns/1ps
`default_nettype none

module sar_adc_control (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        sar_compare,
	input  wire logic        comparator_result,
	input  wire logic        ring_osc_clk,
	input  wire logic        sleep_instruction,
	output logic [7:0]       sar_dac_code,
	output logic             sar_busy,
	output logic [2:0]       channel_select,
	output logic             conv_power_on,
	output logic             reference_source,
	output logic             comparator_enable,
	output logic             comparator_output_enable,
	output logic             comparator_out_pin,
	output logic             comparator_out_pin_oe,
	output logic [2:0]       pin_config_field,
	output logic             amp_one_enable,
	output logic             amp_two_enable,
	output logic [2:0]       amp_one_gain,
	output logic [2:0]       amp_two_gain,
	output logic             wake_up,
	output logic             irq_request
);
	import sar_adc_pkg::*;

	function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] reg_idx);
		idx_hit = (idx == reg_idx);
	endfunction

	logic             wr_pend_r;
	logic [7:0]       wr_idx_r;
	logic             addr_phase;
	logic [7:0]       rd_idx;
	logic [7:0]       rd_val;
	logic [7:0]       wdata;
	logic             wr_run_ch;
	logic             wr_status;
	logic             run_r;
	logic             power_r;
	logic             page_r;
	logic [2:0]       chan_r;
	logic [7:0]       cfg_r;
	logic [7:0]       gain_r;
	logic [7:0]       result_r;
	logic             done_r;
	logic             irq_en_r;
	logic             ref_on_r;
	logic             sleep_d_r;
	logic             sleep_off_r;
	logic             sleep_entry;
	logic             shutoff;
	logic             cmp_s1_r;
	logic             cmp_s2_r;
	logic             res_s1_r;
	logic             res_s2_r;
	logic             ring_s1_r;
	logic             ring_s2_r;
	logic             ring_s3_r;
	logic             ring_armed_r;
	logic [5:0]       div_cnt_r;
	logic [5:0]       div_last;
	logic [1:0]       clk_sel;
	logic             clock_ok;
	logic             conv_tick;
	sar_state_t       state_r;
	logic [7:0]       trial_r;
	logic [7:0]       dac_r;
	logic [7:0]       dac_keep;
	logic             start;
	logic             complete;
	logic             wake_r;
	logic             irq_r;
	logic             cmp_drive_r;
	logic             cmp_pin_r;

	// Bus side: the slave never inserts wait states and always answers OKAY.
	assign addr_phase = hsel & htrans[1] & hready;
	assign rd_idx     = haddr[IDX_MSB:IDX_LSB];
	assign wdata      = hwdata[7:0];
	assign wr_run_ch  = wr_pend_r & idx_hit(wr_idx_r, IDX_RUN_CHANNEL);
	assign wr_status  = wr_pend_r & idx_hit(wr_idx_r, IDX_IRQ_STATUS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 8'h00;
		end else if (addr_phase) begin
			wr_pend_r <= hwrite;
			wr_idx_r  <= rd_idx;
		end else if (hready) begin
			wr_pend_r <= 1'b0;
		end
	end

	always_comb begin
		rd_val = 8'h00;
		if (idx_hit(rd_idx, IDX_RUN_CHANNEL))
			rd_val = {2'h0, page_r, run_r, power_r, chan_r};
		else if (idx_hit(rd_idx, IDX_RESULT))
			rd_val = result_r;
		else if (idx_hit(rd_idx, IDX_PIN_CLOCK))
			rd_val = cfg_r;
		else if (idx_hit(rd_idx, IDX_GAIN))
			rd_val = gain_r;
		else if (idx_hit(rd_idx, IDX_IRQ_STATUS))
			rd_val = {7'h00, done_r};
		else if (idx_hit(rd_idx, IDX_IRQ_MASK))
			rd_val = {7'h00, irq_en_r};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (addr_phase && !hwrite) begin
			hrdata <= {24'h00_0000, rd_val};
		end
	end

	// Plain configuration registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r    <= REG_RESET;
			gain_r   <= REG_RESET;
			irq_en_r <= 1'b0;
			power_r  <= 1'b0;
			page_r   <= 1'b0;
		end else begin
			if (wr_pend_r && idx_hit(wr_idx_r, IDX_PIN_CLOCK))
				cfg_r <= wdata;
			if (wr_pend_r && idx_hit(wr_idx_r, IDX_GAIN))
				gain_r <= wdata;
			if (wr_pend_r && idx_hit(wr_idx_r, IDX_IRQ_MASK))
				irq_en_r <= wdata[IRQ_EN_BIT];
			if (wr_run_ch) begin
				power_r <= wdata[POWER_BIT];
				page_r  <= wdata[PAGE_BIT];
			end
		end
	end

	// The channel is frozen while a result is pending, so the sample matches the field.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			chan_r <= 3'h0;
		else if (wr_run_ch && !done_r && !run_r)
			chan_r <= wdata[CH_LSB +: 3];
	end

	// Synchronisers for the analog comparators and the ring oscillator.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_s1_r  <= 1'b0;
			cmp_s2_r  <= 1'b0;
			res_s1_r  <= 1'b0;
			res_s2_r  <= 1'b0;
			ring_s1_r <= 1'b0;
			ring_s2_r <= 1'b0;
			ring_s3_r <= 1'b0;
		end else begin
			cmp_s1_r  <= sar_compare;
			cmp_s2_r  <= cmp_s1_r;
			res_s1_r  <= comparator_result;
			res_s2_r  <= res_s1_r;
			ring_s1_r <= ring_osc_clk;
			ring_s2_r <= ring_s1_r;
			ring_s3_r <= ring_s2_r;
		end
	end

	// Sleep entry without the interrupt enable shuts the converter down.
	assign sleep_entry = sleep_instruction & ~sleep_d_r;
	assign shutoff     = sleep_entry & ~irq_en_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_d_r   <= 1'b0;
			sleep_off_r <= 1'b0;
		end else begin
			sleep_d_r <= sleep_instruction;
			if (shutoff)
				sleep_off_r <= 1'b1;
			else if (!sleep_instruction)
				sleep_off_r <= 1'b0;
		end
	end

	// Conversion clock: a one-cycle enable from the divider or from a ring edge.
	assign clk_sel = cfg_r[CLK_SEL_LSB +: 2];

	always_comb begin
		case (clk_sel)
			CLK_SEL_DIV4:  div_last = DIV4_LAST;
			CLK_SEL_DIV16: div_last = DIV16_LAST;
			CLK_SEL_DIV64: div_last = DIV64_LAST;
			default:       div_last = DIV4_LAST;
		endcase
	end

	// The divided system clock stops in sleep; only the ring oscillator keeps running.
	assign clock_ok  = !sleep_instruction || (clk_sel == CLK_SEL_RING);
	assign conv_tick = clock_ok && (state_r == ST_CONVERT) &&
		((clk_sel == CLK_SEL_RING) ? (ring_s2_r & ~ring_s3_r & ring_armed_r) :
			(div_cnt_r == div_last));

	// A ring edge can land just after the start, before the comparator has settled on
	// the first trial, so the first ring edge only opens the first full period.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ring_armed_r <= 1'b0;
		else if (state_r != ST_CONVERT)
			ring_armed_r <= 1'b0;
		else if (ring_s2_r && !ring_s3_r)
			ring_armed_r <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt_r <= 6'h00;
		else if (state_r != ST_CONVERT || div_cnt_r >= div_last)
			div_cnt_r <= 6'h00;
		else if (clock_ok)
			div_cnt_r <= div_cnt_r + 6'h01;
	end

	// Successive approximation, most significant bit first.
	assign start    = wr_run_ch && wdata[RUN_BIT] && !run_r && !shutoff;
	assign dac_keep = cmp_s2_r ? dac_r : (dac_r & ~trial_r);
	assign complete = conv_tick && trial_r[0] && !shutoff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			trial_r <= 8'h00;
			dac_r   <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_CONVERT;
						trial_r <= SAR_MSB;
						dac_r   <= SAR_MSB;
					end
				end
				ST_CONVERT: begin
					if (shutoff || complete) begin
						state_r <= ST_IDLE;
						trial_r <= 8'h00;
					end else if (conv_tick) begin
						trial_r <= trial_r >> 1;
						dac_r   <= dac_keep | (trial_r >> 1);
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Software can only set the run bit; a written zero is ignored.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			run_r <= 1'b0;
		else if (complete || shutoff)
			run_r <= 1'b0;
		else if (start)
			run_r <= 1'b1;
	end

	// A completion in the same cycle as a clearing write keeps the flag set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_r <= 8'h00;
			done_r   <= 1'b0;
		end else begin
			if (complete)
				result_r <= dac_keep;
			if (complete)
				done_r <= 1'b1;
			else if (wr_status)
				done_r <= done_r & wdata[DONE_FLAG_BIT];
		end
	end

	// Status outputs and wake-up.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_r   <= 1'b0;
			irq_r    <= 1'b0;
			ref_on_r <= 1'b0;
		end else begin
			wake_r   <= complete && sleep_instruction && irq_en_r;
			irq_r    <= done_r && irq_en_r;
			ref_on_r <= power_r && !sleep_off_r && !shutoff;
		end
	end

	// Comparator pin driver; the pin is driven only when both the enable and output bits are set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_drive_r <= 1'b0;
			cmp_pin_r   <= 1'b0;
		end else begin
			cmp_drive_r <= cfg_r[CMP_EN_BIT] && cfg_r[CMP_OUT_BIT];
			cmp_pin_r   <= res_s2_r && cfg_r[CMP_EN_BIT];
		end
	end

	assign sar_dac_code             = dac_r;
	assign sar_busy                 = run_r;
	assign channel_select           = chan_r;
	assign conv_power_on            = ref_on_r;
	assign reference_source         = cfg_r[REF_BIT];
	assign comparator_enable        = cfg_r[CMP_EN_BIT];
	assign comparator_output_enable = cfg_r[CMP_OUT_BIT];
	assign comparator_out_pin       = cmp_pin_r;
	assign comparator_out_pin_oe    = cmp_drive_r;
	assign pin_config_field         = cfg_r[PIN_CFG_LSB +: 3];
	assign amp_one_enable           = gain_r[AMP1_EN_BIT];
	assign amp_two_enable           = gain_r[AMP2_EN_BIT];
	assign amp_one_gain             = gain_r[GAIN1_LSB +: 3];
	assign amp_two_gain             = gain_r[GAIN2_LSB +: 3];
	assign wake_up                  = wake_r;
	assign irq_request              = irq_r;

	// Counts conversion periods so the eight-period length can be checked.
	logic [3:0] tick_cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tick_cnt_r <= 4'h0;
		else if (start)
			tick_cnt_r <= 4'h0;
		else if (conv_tick)
			tick_cnt_r <= tick_cnt_r + 4'h1;
	end

	property p_start;
		@(posedge hclk) disable iff (!hresetn)
		start |=> run_r && (state_r == ST_CONVERT) && (dac_r == 8'h80);
	endproperty
	a_start: assert property (p_start) else $error("run write did not start");

	property p_run_hold;
		@(posedge hclk) disable iff (!hresetn)
		run_r && !complete && !shutoff |=> run_r;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run bit cleared early");

	property p_power_off;
		@(posedge hclk) disable iff (!hresetn)
		!power_r |=> !conv_power_on;
	endproperty
	a_power_off: assert property (p_power_off) else $error("reference on unpowered");

	property p_chan_frozen;
		@(posedge hclk) disable iff (!hresetn)
		(done_r || run_r) |=> $stable(chan_r);
	endproperty
	a_chan_frozen: assert property (p_chan_frozen) else $error("channel changed");

	property p_div4;
		@(posedge hclk) disable iff (!hresetn)
		conv_tick && (clk_sel == CLK_SEL_DIV4) && $stable(cfg_r) |=> !conv_tick [*3];
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four too fast");

	property p_complete;
		@(posedge hclk) disable iff (!hresetn)
		complete |=> !run_r && done_r && (result_r == $past(dac_keep));
	endproperty
	a_complete: assert property (p_complete) else $error("completion wrong");

	property p_eight;
		@(posedge hclk) disable iff (!hresetn)
		complete |-> (tick_cnt_r == 4'h7);
	endproperty
	a_eight: assert property (p_eight) else $error("not eight periods");

	property p_sleep_gate;
		@(posedge hclk) disable iff (!hresetn)
		sleep_instruction && (clk_sel != CLK_SEL_RING) |-> !conv_tick;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("tick in sleep");

	property p_wake;
		@(posedge hclk) disable iff (!hresetn)
		complete && sleep_instruction && irq_en_r |=> wake_up ##1 !wake_up;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake pulse");

	property p_shutoff;
		@(posedge hclk) disable iff (!hresetn)
		shutoff |=> !run_r && !conv_power_on && (state_r == ST_IDLE);
	endproperty
	a_shutoff: assert property (p_shutoff) else $error("sleep did not shut off");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		complete |=> done_r ##1 (irq_request == irq_en_r || $changed(irq_en_r));
	endproperty
	a_irq: assert property (p_irq) else $error("request not gated by mask");

endmodule

`default_nettype wire

/* rtl/sar_adc_pkg.sv */
package sar_adc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_RUN_CHANNEL = 8'h09;
	localparam logic [7:0] IDX_RESULT      = 8'h0A;
	localparam logic [7:0] IDX_PIN_CLOCK   = 8'h0B;
	localparam logic [7:0] IDX_GAIN        = 8'h0C;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'h0D;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'h0E;
	localparam int         IDX_LSB         = 2;
	localparam int         IDX_MSB         = 9;

	// Run and channel register fields.
	localparam int PAGE_BIT  = 5;
	localparam int RUN_BIT   = 4;
	localparam int POWER_BIT = 3;
	localparam int CH_LSB    = 0;

	// Pin and clock configuration fields.
	localparam int REF_BIT      = 7;
	localparam int CMP_EN_BIT   = 6;
	localparam int CMP_OUT_BIT  = 5;
	localparam int PIN_CFG_LSB  = 2;
	localparam int CLK_SEL_LSB  = 0;

	// Gain register fields.
	localparam int AMP2_EN_BIT = 7;
	localparam int AMP1_EN_BIT = 6;
	localparam int GAIN2_LSB   = 3;
	localparam int GAIN1_LSB   = 0;

	// Interrupt status and mask fields.
	localparam int DONE_FLAG_BIT = 0;
	localparam int IRQ_EN_BIT    = 0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] SAR_MSB   = 8'h80;

	// Conversion clock selector codes and last count of each divider.
	localparam logic [1:0] CLK_SEL_DIV4  = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV16 = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV64 = 2'h2;
	localparam logic [1:0] CLK_SEL_RING  = 2'h3;
	localparam logic [5:0] DIV4_LAST     = 6'h03;
	localparam logic [5:0] DIV16_LAST    = 6'h0F;
	localparam logic [5:0] DIV64_LAST    = 6'h3F;

	typedef enum logic {ST_IDLE, ST_CONVERT} sar_state_t;

endpackage
